// *** rtl/src_soft_reset_ctrl.sv ***
// counters and software reset control of the switch core
//
// Summary of operation
// - timer count view returns live down-counter in bits 15:0, resets to FFFF, read-only.
// - enabled timer loads preset and decrements; enable falling returns preset to FFFF.
// - 32-bit free counter starts at zero, increments every 25 MHz tick, read-only.
// - free counter wraps from its maximum to zero and keeps counting silently.
// - free counter may take up to 160 ns to read cleared after a reset.
// - writing one to bit 3 resets virtual PHY; bit clears at its release.
// - bit 2 resets second port PHY for at least 102 us, then self-clears.
// - bit 1 resets first port PHY for at least 102 us, then self-clears.
// - writes to a reset request bit are ignored while that bit is set.
// - bit 0 resets the core except PLL and PHYs; clears at core release.
// - after core reset the EEPROM reload starts automatically, without resetting PHYs.
// - core reset returns system registers to defaults, except bits kept through reset.
// - core reset aborts any EEPROM command in progress, reload included.
// - endian check returns 87654321h out of reset and never that pattern during it.
// - the configuration loader cannot write any reset request bit.
// - reset control stays readable during core reset; the data then may be invalid.
// - either 16-bit half of the reset control register may be read alone.
`timescale 1ns/100ps
`default_nettype none
`include "src_defines.svh"

module src_soft_reset_ctrl #(
	parameter int unsigned PHY_HOLD_CYCLES = `SRC_PHY_HOLD_CYCLES
) (
	input wire logic I_REF_CLK,
	input wire logic I_NRST,
	input wire src_pkg::src_req_t I_REQ,
	output src_pkg::src_rsp_t O_RSP,
	output logic O_VIRTUAL_PHY_RST,
	output logic O_FIRST_PORT_PHY_RST,
	output logic O_SECOND_PORT_PHY_RST,
	output logic O_CORE_RST,
	output logic O_EE_ABORT,
	output logic O_EE_RELOAD
);
	import src_pkg::*;

	localparam int FREE_CLR_BOUND = `SRC_FREE_CLR_CYCLES;

	src_core_state_t state;
	src_core_state_t next_state;
	logic core_rst;
	logic host_wr;
	logic wr_rst_ctl;
	logic wr_cfg;
	logic [3:0] set_req;
	logic [3:0] release_req;
	logic [3:0] rst_req;
	logic [2:0] div_cnt;
	logic tick;
	logic [31:0] free_count;
	logic timer_en;
	logic next_timer_en;
	logic [15:0] timer_preset;
	logic [15:0] timer_count;
	logic vphy_busy;
	logic vphy_done;
	logic phy1_busy;
	logic phy1_done;
	logic phy2_busy;
	logic phy2_done;
	logic core_busy;
	logic core_done;
	logic [31:0] read_word;

	// ----------------------------------------
	// write decode
	// ----------------------------------------

	// no register, the reset control register included, takes writes while the core is held
	assign core_rst = (state == SRC_CORE_HOLD);
	assign host_wr = I_REQ.valid && I_REQ.write && !core_rst;
	assign wr_rst_ctl = host_wr && !I_REQ.loader && I_REQ.lanes[0]
		&& (I_REQ.addr == `SRC_OFF_SOFT_RESET_CONTROL);
	assign wr_cfg = host_wr && (I_REQ.addr == `SRC_OFF_TIMER_CONFIG);
	// only ones start a reset, and a bit already set ignores the write
	assign set_req = {4{wr_rst_ctl}} & I_REQ.wdata[3:0] & ~rst_req;
	assign release_req = {vphy_done, phy2_done, phy1_done, core_done};

	// ----------------------------------------
	// reset request bits and hold timers
	// ----------------------------------------

	// self-clearing request bits; set and release never meet since set needs the bit clear
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rst_req <= 4'h0;
		end else begin
			rst_req <= (rst_req | set_req) & ~release_req;
		end
	end

	// the virtual PHY needs only a short pulse
	src_hold_timer #(.CYCLES(`SRC_VPHY_HOLD_CYCLES)) u_vphy_hold (
		.i_clk(I_REF_CLK),
		.i_nrst(I_NRST),
		.i_start(set_req[`SRC_BIT_VPHY]),
		.o_busy(vphy_busy),
		.o_done(vphy_done)
	);

	// port PHYs are held for the full analog settling time
	src_hold_timer #(.CYCLES(PHY_HOLD_CYCLES)) u_phy1_hold (
		.i_clk(I_REF_CLK),
		.i_nrst(I_NRST),
		.i_start(set_req[`SRC_BIT_PHY1]),
		.o_busy(phy1_busy),
		.o_done(phy1_done)
	);

	src_hold_timer #(.CYCLES(PHY_HOLD_CYCLES)) u_phy2_hold (
		.i_clk(I_REF_CLK),
		.i_nrst(I_NRST),
		.i_start(set_req[`SRC_BIT_PHY2]),
		.o_busy(phy2_busy),
		.o_done(phy2_done)
	);

	src_hold_timer #(.CYCLES(`SRC_CORE_HOLD_CYCLES)) u_core_hold (
		.i_clk(I_REF_CLK),
		.i_nrst(I_NRST),
		.i_start(set_req[`SRC_BIT_CORE]),
		.o_busy(core_busy),
		.o_done(core_done)
	);

	assign O_VIRTUAL_PHY_RST = vphy_busy;
	assign O_FIRST_PORT_PHY_RST = phy1_busy;
	assign O_SECOND_PORT_PHY_RST = phy2_busy;

	// ----------------------------------------
	// core reset sequencing
	// ----------------------------------------

	// next state
	always_comb begin
		next_state = state;
		unique case (state)
			SRC_RUN: begin
				if (set_req[`SRC_BIT_CORE]) begin
					next_state = SRC_CORE_HOLD;
				end
			end
			SRC_CORE_HOLD: begin
				if (core_done) begin
					next_state = SRC_RUN;
				end
			end
			default: begin
				next_state = SRC_RUN;
			end
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			state <= SRC_RUN;
		end else begin
			state <= next_state;
		end
	end

	assign O_CORE_RST = core_rst;

	// abort on entry, reload on release; PHY holds are not touched by either
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_EE_ABORT <= 1'b0;
			O_EE_RELOAD <= 1'b0;
		end else begin
			O_EE_ABORT <= set_req[`SRC_BIT_CORE];
			O_EE_RELOAD <= core_done;
		end
	end

	// ----------------------------------------
	// free-running counter
	// ----------------------------------------

	// 25 MHz enable from the 200 MHz clock
	assign tick = (div_cnt == 3'(`SRC_FREE_DIV - 1));

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			div_cnt <= 3'h0;
		end else begin
			div_cnt <= tick ? 3'h0 : div_cnt + 3'h1;
		end
	end

	// cleared at once by the core reset, well inside the allowed settling time
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			free_count <= 32'h0000_0000;
		end else if (core_rst) begin
			free_count <= 32'h0000_0000;
		end else if (tick) begin
			free_count <= free_count + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// general timer configuration and count
	// ----------------------------------------

	always_comb begin
		next_timer_en = timer_en;
		if (wr_cfg && I_REQ.lanes[1]) begin
			next_timer_en = I_REQ.wdata[`SRC_TIMER_EN_BIT];
		end
	end

	// the falling enable wins over a preset written in the same access
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			timer_en <= 1'b0;
			timer_preset <= `SRC_PRESET_DEFAULT;
		end else if (core_rst) begin
			timer_en <= 1'b0;
			timer_preset <= `SRC_PRESET_DEFAULT;
		end else begin
			timer_en <= next_timer_en;
			if (timer_en && !next_timer_en) begin
				timer_preset <= `SRC_PRESET_DEFAULT;
			end else if (wr_cfg && I_REQ.lanes[0]) begin
				timer_preset <= I_REQ.wdata[15:0];
			end
		end
	end

	src_down_timer u_general_down_timer (
		.i_clk(I_REF_CLK),
		.i_nrst(I_NRST),
		.i_clear(core_rst),
		.i_tick(tick),
		.i_en(timer_en),
		.i_preset(timer_preset),
		.o_count(timer_count)
	);

	// ----------------------------------------
	// read path
	// ----------------------------------------

	// during core reset only reset control answers; endian check then reads zero
	always_comb begin
		read_word = 32'h0000_0000;
		if (I_REQ.addr == `SRC_OFF_SOFT_RESET_CONTROL) begin
			read_word = {28'h000_0000, rst_req};
		end else if (!core_rst) begin
			unique case (I_REQ.addr)
				`SRC_OFF_ENDIAN_CHECK: read_word = `SRC_ENDIAN_PATTERN;
				`SRC_OFF_TIMER_CONFIG: read_word = {2'b00, timer_en, 13'h0000, timer_preset};
				`SRC_OFF_TIMER_COUNT: read_word = {16'h0000, timer_count};
				`SRC_OFF_FREE_RUN: read_word = free_count;
				default: read_word = 32'h0000_0000;
			endcase
		end
	end

	// one-cycle answer; unselected half reads zero
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_RSP <= '0;
		end else begin
			O_RSP.valid <= I_REQ.valid;
			if (I_REQ.valid && !I_REQ.write) begin
				O_RSP.rdata <= read_word & {{16{I_REQ.lanes[1]}}, {16{I_REQ.lanes[0]}}};
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------

	logic [15:0] phy1_len;
	logic [15:0] phy2_len;

	// cycles each port PHY reset has been held
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			phy1_len <= 16'h0000;
			phy2_len <= 16'h0000;
		end else begin
			phy1_len <= phy1_busy ? phy1_len + 16'h0001 : 16'h0000;
			phy2_len <= phy2_busy ? phy2_len + 16'h0001 : 16'h0000;
		end
	end

	property p_free_wrap;
		@(posedge I_REF_CLK) disable iff (!I_NRST)
		tick && !core_rst && (free_count == 32'hFFFF_FFFF) |=> (free_count == 32'h0000_0000);
	endproperty
	a_free_wrap: assert property (p_free_wrap) else $error("free counter did not wrap");

	property p_free_step;
		@(posedge I_REF_CLK) disable iff (!I_NRST)
		!core_rst ##1 !core_rst |-> free_count == $past(free_count) + 32'($past(tick));
	endproperty
	a_free_step: assert property (p_free_step) else $error("free counter step wrong");

	property p_free_clear;
		@(posedge I_REF_CLK) disable iff (!I_NRST)
		$rose(core_rst) |-> ##[0:FREE_CLR_BOUND] (free_count == 32'h0000_0000);
	endproperty
	a_free_clear: assert property (p_free_clear) else $error("free counter not cleared");

	property p_phy1_hold;
		@(posedge I_REF_CLK) disable iff (!I_NRST)
		$fell(phy1_busy) |-> (phy1_len >= 16'(PHY_HOLD_CYCLES)) && !rst_req[`SRC_BIT_PHY1];
	endproperty
	a_phy1_hold: assert property (p_phy1_hold) else $error("first PHY reset too short");

	property p_phy2_hold;
		@(posedge I_REF_CLK) disable iff (!I_NRST)
		$fell(phy2_busy) |-> (phy2_len >= 16'(PHY_HOLD_CYCLES)) && !rst_req[`SRC_BIT_PHY2];
	endproperty
	a_phy2_hold: assert property (p_phy2_hold) else $error("second PHY reset too short");

	property p_vphy_clear;
		@(posedge I_REF_CLK) disable iff (!I_NRST)
		$fell(O_VIRTUAL_PHY_RST) |-> !rst_req[`SRC_BIT_VPHY];
	endproperty
	a_vphy_clear: assert property (p_vphy_clear) else $error("virtual PHY bit stuck");

	property p_loader_blocked;
		@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_REQ.valid && I_REQ.write && I_REQ.loader && (rst_req == 4'h0) |=> (rst_req == 4'h0);
	endproperty
	a_loader_blocked: assert property (p_loader_blocked) else $error("loader set a reset bit");

	// the release cycle is left out: there the hold ends on time whatever is written
	property p_ignore_while_set;
		@(posedge I_REF_CLK) disable iff (!I_NRST)
		rst_req[`SRC_BIT_PHY1] && wr_rst_ctl && !phy1_done
		|=> phy1_busy && rst_req[`SRC_BIT_PHY1] && !$stable(phy1_len);
	endproperty
	a_ignore_while_set: assert property (p_ignore_while_set) else $error("write restarted hold");

	property p_endian_in_reset;
		@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_REQ.valid && !I_REQ.write && core_rst |=> (O_RSP.rdata != `SRC_ENDIAN_PATTERN);
	endproperty
	a_endian_in_reset: assert property (p_endian_in_reset) else $error("endian pattern in reset");

	property p_core_abort_reload;
		@(posedge I_REF_CLK) disable iff (!I_NRST)
		$rose(O_CORE_RST) |-> O_EE_ABORT ##1 (O_CORE_RST && !O_EE_RELOAD) [*8] ##[1:300] O_EE_RELOAD;
	endproperty
	a_core_abort_reload: assert property (p_core_abort_reload) else $error("abort or reload missing");

	property p_preset_back;
		@(posedge I_REF_CLK) disable iff (!I_NRST)
		$fell(timer_en) |-> (timer_preset == `SRC_PRESET_DEFAULT);
	endproperty
	a_preset_back: assert property (p_preset_back) else $error("preset not restored");

	property p_half_read;
		@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_REQ.valid && !I_REQ.write && (I_REQ.lanes == 2'b01) |=> O_RSP.valid && (O_RSP.rdata[31:16] == 16'h0000);
	endproperty
	a_half_read: assert property (p_half_read) else $error("upper half leaked");

	c_phy1_done: cover property (@(posedge I_REF_CLK) disable iff (!I_NRST) phy1_done);
	c_core_cycle: cover property (@(posedge I_REF_CLK) disable iff (!I_NRST) $fell(O_CORE_RST));
	c_free_wrap: cover property (@(posedge I_REF_CLK) disable iff (!I_NRST) tick && (free_count == 32'hFFFF_FFFF));
endmodule

`default_nettype wire

// *** rtl/src_defines.svh ***
// offsets, field positions, reset values and timing counts of the soft reset control block
`ifndef SRC_DEFINES_SVH
`define SRC_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SRC_OFF_ENDIAN_CHECK 12'h064
`define SRC_OFF_TIMER_CONFIG 12'h08C
`define SRC_OFF_TIMER_COUNT 12'h090
`define SRC_OFF_FREE_RUN 12'h09C
`define SRC_OFF_SOFT_RESET_CONTROL 12'h1F8

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SRC_ENDIAN_PATTERN 32'h8765_4321
`define SRC_TIMER_EN_BIT 29
`define SRC_PRESET_DEFAULT 16'hFFFF
`define SRC_BIT_CORE 0
`define SRC_BIT_PHY1 1
`define SRC_BIT_PHY2 2
`define SRC_BIT_VPHY 3

// ----------------------------------------
// timing
// ----------------------------------------
`define SRC_CLK_MHZ 200
`define SRC_FREE_MHZ 25
`define SRC_FREE_DIV (`SRC_CLK_MHZ / `SRC_FREE_MHZ)
`define SRC_PHY_HOLD_NS 102000
`define SRC_PHY_HOLD_CYCLES ((`SRC_PHY_HOLD_NS * `SRC_CLK_MHZ + 999) / 1000)
`define SRC_FREE_CLR_NS 160
`define SRC_FREE_CLR_CYCLES ((`SRC_FREE_CLR_NS * `SRC_CLK_MHZ) / 1000)
`define SRC_VPHY_HOLD_CYCLES 16
`define SRC_CORE_HOLD_CYCLES 16

`endif

// *** rtl/src_pkg.sv ***
// types shared by the soft reset control block
package src_pkg;

	// one register access from the serial management side or the configuration loader
	typedef struct packed {
		logic valid;
		logic write;
		logic loader;
		logic [1:0] lanes;
		logic [11:0] addr;
		logic [31:0] wdata;
	} src_req_t;

	// answer, one cycle after the request
	typedef struct packed {
		logic valid;
		logic [31:0] rdata;
	} src_rsp_t;

	typedef enum logic [1:0] {
		SRC_RUN = 2'b01,
		SRC_CORE_HOLD = 2'b10
	} src_core_state_t;

endpackage

// *** rtl/src_hold_timer.sv ***
// fixed-length reset hold timer with a release pulse
`timescale 1ns/100ps
`default_nettype none

module src_hold_timer #(
	parameter int unsigned CYCLES = 16
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_start,
	output logic o_busy,
	output logic o_done
);
	localparam int unsigned W = $clog2(CYCLES + 1);
	logic [W-1:0] remain;

	// release in the last busy cycle, so busy stands exactly CYCLES cycles
	assign o_done = o_busy && (remain == W'(1));

	// count down; a start while busy is ignored
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			remain <= '0;
		end else if (i_start && !o_busy) begin
			remain <= W'(CYCLES);
		end else if (o_busy) begin
			remain <= remain - 1'b1;
		end
	end

	// busy flag
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_busy <= 1'b0;
		end else if (i_start && !o_busy) begin
			o_busy <= 1'b1;
		end else if (o_done) begin
			o_busy <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// *** rtl/src_down_timer.sv ***
// general purpose down-counter loaded from its preset
`timescale 1ns/100ps
`default_nettype none

module src_down_timer (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_clear,
	input wire logic i_tick,
	input wire logic i_en,
	input wire logic [15:0] i_preset,
	output logic [15:0] o_count
);
	logic en_q;

	// remember the enable to catch its rising edge
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			en_q <= 1'b0;
		end else begin
			en_q <= i_en && !i_clear;
		end
	end

	// load on enable, decrement on tick, reload from preset past zero
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_count <= 16'hFFFF;
		end else if (i_clear) begin
			o_count <= 16'hFFFF;
		end else if (i_en && !en_q) begin
			o_count <= i_preset;
		end else if (i_en && i_tick) begin
			o_count <= (o_count == 16'h0000) ? i_preset : o_count - 16'h0001;
		end
	end
endmodule

`default_nettype wire

// *** sim/src_host_model.sv ***
// host side model that issues register accesses and polls for reset completion
`timescale 1ns/100ps
`default_nettype none
`include "src_defines.svh"

module src_host_model (
	input wire logic i_clk,
	input wire src_pkg::src_rsp_t i_rsp,
	output src_pkg::src_req_t o_req
);
	import src_pkg::*;

	// ----------------------------------------
	// single access
	// ----------------------------------------
	// idle request until the first access
	initial begin
		o_req = '0;
	end

	// request stands one edge, the answer is taken one cycle later
	// read wdata is scrambled each time, so the block cannot lean on it
	task automatic do_access(input logic wr, input logic ldr, input logic [1:0] ln, input logic [11:0] ad,
		input logic [31:0] wd, output logic [31:0] rd, output logic ok);
		@(posedge i_clk);
		o_req <= '{valid: 1'b1, write: wr, loader: ldr, lanes: ln, addr: ad, wdata: wr ? wd : ~o_req.wdata};
		@(posedge i_clk);
		o_req.valid <= 1'b0;
		#1;
		ok = i_rsp.valid;
		rd = i_rsp.rdata;
	endtask

	// ----------------------------------------
	// reset completion
	// ----------------------------------------
	// the endian check reads zero during reset, so only the full pattern counts as done
	task automatic poll_ready(input int limit, output logic ok);
		logic [31:0] rd;
		logic a;
		ok = 1'b0;
		for (int i = 0; i < limit && ok !== 1'b1; i++) begin
			do_access(1'b0, 1'b0, 2'b11, `SRC_OFF_ENDIAN_CHECK, 32'h0000_0000, rd, a);
			ok = (a === 1'b1) && (rd === `SRC_ENDIAN_PATTERN);
		end
	endtask
endmodule
`default_nettype wire

// *** sim/counters_and_soft_reset_control_test.sv ***
// self-checking testbench of the counters and soft reset control block
`timescale 1ns/100ps
`default_nettype none
`include "src_defines.svh"

module counters_and_soft_reset_control_test;
	import src_pkg::*;

	// ----------------------------------------
	// environment
	// ----------------------------------------
	// short hold keeps the run brief; both port PHY hold checks follow from it
	localparam int unsigned HOLD = 40;
	logic clk;
	logic nrst;
	src_req_t req;
	src_rsp_t rsp;
	logic virtual_phy_reset_request, first_port_phy_reset_request, second_port_phy_reset_request, core_rst, ee_abort, ee_reload;
	logic [3:0] rst_vec;
	logic [4:0] fall_snap;
	logic ok;
	logic [31:0] v, w;
	int run_len[4];
	int last_len[4];
	int n_mismatch;
	int checked;

	assign rst_vec = {virtual_phy_reset_request, second_port_phy_reset_request, first_port_phy_reset_request, core_rst};

	src_soft_reset_ctrl #(.PHY_HOLD_CYCLES(HOLD)) src_soft_reset_ctrl_inst (
		.I_REF_CLK(clk), .I_NRST(nrst), .I_REQ(req), .O_RSP(rsp),
		.O_VIRTUAL_PHY_RST(virtual_phy_reset_request), .O_FIRST_PORT_PHY_RST(first_port_phy_reset_request), .O_SECOND_PORT_PHY_RST(second_port_phy_reset_request),
		.O_CORE_RST(core_rst), .O_EE_ABORT(ee_abort), .O_EE_RELOAD(ee_reload)
	);

	src_host_model src_host_model_inst (.i_clk(clk), .i_rsp(rsp), .o_req(req));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// length of each reset pulse in cycles, latched when it falls
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (rst_vec[i] === 1'b1) begin
				run_len[i] <= run_len[i] + 1;
			end else if (run_len[i] != 0) begin
				last_len[i] <= run_len[i];
				run_len[i] <= 0;
			end
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_rng(input string name, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
		checked++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_mismatch++;
			$display("ERROR %s expected %h..%h seen %h", name, lo, hi, got);
		end
	endtask

	task automatic reg_wr(input logic ldr, input logic [11:0] ad, input logic [31:0] wd);
		logic [31:0] rd;
		logic a;
		src_host_model_inst.do_access(1'b1, ldr, 2'b11, ad, wd, rd, a);
		chk("write answer", 32'h0000_0001, {31'h0000_0000, a});
	endtask

	task automatic reg_rd(input logic [1:0] ln, input logic [11:0] ad, output logic [31:0] rd);
		logic a;
		src_host_model_inst.do_access(1'b0, 1'b0, ln, ad, 32'h0000_0000, rd, a);
		chk("read answer", 32'h0000_0001, {31'h0000_0000, a});
	endtask

	// waits, bounded, for one reset output to fall; snapshot taken at the fall
	task automatic wait_low(input int idx);
		for (int i = 0; i < 200 && rst_vec[idx] === 1'b1; i++) begin
			@(posedge clk);
			#1;
			fall_snap = {ee_reload, rst_vec};
		end
		@(posedge clk);
		#1;
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	// main sequence
	initial begin
		nrst = 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		reg_rd(2'b11, `SRC_OFF_FREE_RUN, v);
		chk_rng("free run start", 32'h0000_0000, 32'h0000_0003, v);
		reg_rd(2'b11, `SRC_OFF_TIMER_COUNT, w);
		chk("timer count", 32'h0000_FFFF, w);
		reg_rd(2'b11, `SRC_OFF_SOFT_RESET_CONTROL, w);
		chk("reset control", 32'h0000_0000, w);
		reg_rd(2'b11, `SRC_OFF_ENDIAN_CHECK, w);
		chk("endian", `SRC_ENDIAN_PATTERN, w);
		// reads sampled 80 clocks apart see exactly 10 ticks
		repeat (72) @(posedge clk);
		reg_rd(2'b11, `SRC_OFF_FREE_RUN, w);
		chk("free run step", v + 32'h0000_000A, w);
		$display("test defaults done");
		reg_wr(1'b0, `SRC_OFF_TIMER_CONFIG, 32'h2000_0010);
		repeat (40) @(posedge clk);
		reg_rd(2'b11, `SRC_OFF_TIMER_COUNT, v);
		chk_rng("timer running", 32'h0000_000A, 32'h0000_0010, v);
		repeat (78) @(posedge clk);
		reg_rd(2'b11, `SRC_OFF_TIMER_COUNT, w);
		chk("timer step", v - 32'h0000_000A, w);
		reg_wr(1'b0, `SRC_OFF_TIMER_CONFIG, 32'h0000_0010);
		reg_rd(2'b11, `SRC_OFF_TIMER_CONFIG, w);
		chk("preset after disable", 32'h0000_FFFF, w);
		$display("test timer done");
		reg_wr(1'b0, `SRC_OFF_SOFT_RESET_CONTROL, 32'h0000_0002);
		reg_rd(2'b11, `SRC_OFF_SOFT_RESET_CONTROL, w);
		chk("phy1 request", 32'h0000_0002, w);
		reg_wr(1'b0, `SRC_OFF_SOFT_RESET_CONTROL, 32'h0000_0002);
		reg_wr(1'b0, `SRC_OFF_SOFT_RESET_CONTROL, 32'h0000_0000);
		reg_rd(2'b11, `SRC_OFF_SOFT_RESET_CONTROL, w);
		chk("phy1 kept", 32'h0000_0002, w);
		wait_low(1);
		chk("phy1 hold", 32'(HOLD), 32'(last_len[1]));
		reg_rd(2'b11, `SRC_OFF_SOFT_RESET_CONTROL, w);
		chk("phy1 cleared", 32'h0000_0000, w);
		$display("test phy1 done");
		reg_wr(1'b0, `SRC_OFF_SOFT_RESET_CONTROL, 32'hFFFF_FFFC);
		reg_rd(2'b01, `SRC_OFF_SOFT_RESET_CONTROL, w);
		chk("low half", 32'h0000_000C, w);
		reg_rd(2'b10, `SRC_OFF_SOFT_RESET_CONTROL, w);
		chk("high half", 32'h0000_0000, w);
		wait_low(3);
		chk("vphy hold", 32'h0000_0010, 32'(last_len[3]));
		wait_low(2);
		chk("phy2 hold", 32'(HOLD), 32'(last_len[2]));
		reg_rd(2'b11, `SRC_OFF_SOFT_RESET_CONTROL, w);
		chk("pair cleared", 32'h0000_0000, w);
		reg_wr(1'b1, `SRC_OFF_SOFT_RESET_CONTROL, 32'h0000_000F);
		@(posedge clk);
		#1;
		chk("loader resets", 32'h0000_0000, {28'h000_0000, rst_vec});
		$display("test phy resets done");
		reg_wr(1'b0, `SRC_OFF_TIMER_CONFIG, 32'h0000_1234);
		reg_wr(1'b0, `SRC_OFF_SOFT_RESET_CONTROL, 32'h0000_0001);
		chk("core start", 32'h0000_0003, {26'h000_0000, ee_reload, rst_vec[3:1], ee_abort, core_rst});
		reg_rd(2'b11, `SRC_OFF_SOFT_RESET_CONTROL, w);
		chk("control in reset", 32'h0000_0001, w);
		reg_rd(2'b11, `SRC_OFF_ENDIAN_CHECK, w);
		chk("endian in reset", 32'h0000_0000, w);
		reg_wr(1'b0, `SRC_OFF_SOFT_RESET_CONTROL, 32'h0000_000F);
		wait_low(0);
		chk("core hold", 32'h0000_0010, 32'(last_len[0]));
		chk("reload at release", 32'h0000_0010, {27'h000_0000, fall_snap});
		src_host_model_inst.poll_ready(20, ok);
		chk("ready", 32'h0000_0001, {31'h0000_0000, ok});
		reg_rd(2'b11, `SRC_OFF_FREE_RUN, w);
		chk_rng("free run cleared", 32'h0000_0000, 32'h0000_0007, w);
		reg_rd(2'b11, `SRC_OFF_TIMER_CONFIG, w);
		chk("config default", 32'h0000_FFFF, w);
		reg_rd(2'b11, `SRC_OFF_SOFT_RESET_CONTROL, w);
		chk("core cleared", 32'h0000_0000, w);
		$display("test core reset done");
		report_and_stop;
	end

	// watchdog, several times the expected run length
	initial begin
		repeat (4000) @(posedge clk);
		n_mismatch++;
		$display("ERROR watchdog expected finish seen hang");
		report_and_stop;
	end
endmodule
`default_nettype wire
